// File: design/dbl_pkg.sv
// shared constants, opcodes, states and carriers for the debug lock and chip info block
// assumes a single 100 MHz core clock domain
package dbl_pkg;

  // memory-space offsets of the readable registers
  localparam logic [15:0] OFS_CHIP_VERSION    = 16'h6249;
  localparam logic [15:0] OFS_CHIP_IDENTIFIER = 16'h624a;
  localparam logic [15:0] OFS_DEBUG_BURST     = 16'h6260;
  localparam logic [15:0] OFS_CHIP_INFO_LOW   = 16'h6276;
  localparam logic [15:0] OFS_CHIP_INFO_HIGH  = 16'h6277;
  localparam logic [15:0] OFS_LOCK_STRUCT     = 16'h7ff0;

  // lock structure layout
  localparam int          LOCK_BITS      = 128;
  localparam int          LOCK_BYTES     = 16;
  localparam int          DBG_LOCK_POS   = 127;
  localparam int          PAGE_BYTES     = 2048;
  localparam int          FLASH_AW       = 18;
  localparam logic [LOCK_BITS-1:0] LOCK_ERASED = {LOCK_BITS{1'b1}};

  // reset values
  localparam logic [7:0]  DEBUG_BURST_RST = 8'h00;
  localparam logic [7:0]  DEBUG_CFG_RST   = 8'h00;

  // debug configuration field
  localparam int          CFG_SHUTDOWN_POS = 5;

  // chip info fixed fields
  localparam int          INFO_FLASH_LSB = 4;
  localparam int          INFO_USB_POS   = 3;
  localparam int          INFO_ONE_POS   = 2;
  localparam logic [2:0]  FLASH_32K      = 3'h1;
  localparam logic [2:0]  FLASH_64K      = 3'h2;
  localparam logic [2:0]  FLASH_128K     = 3'h3;
  localparam logic [2:0]  FLASH_256K     = 3'h4;

  // timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          WAKE_NS       = 2000;
  localparam int          WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    OP_CHIP_ERASE  = 4'h0,
    OP_READ_STATUS = 4'h1,
    OP_ID_QUERY    = 4'h2,
    OP_HALT        = 4'h3,
    OP_RESUME      = 4'h4,
    OP_WR_CONFIG   = 4'h5,
    OP_RD_CONFIG   = 4'h6,
    OP_BURST_WRITE = 4'h7,
    OP_DEBUG_INSTR = 4'h8,
    OP_STEP        = 4'h9
  } dbl_op_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10,
    ST_HALT  = 2'b11
  } dbl_state_t;

  typedef struct packed {
    dbl_op_t    op;
    logic [7:0] data;
  } dbl_cmd_t;

  typedef struct packed {
    logic                erase;
    logic [FLASH_AW-1:0] addr;
    logic [7:0]          data;
  } dbl_flash_req_t;

  typedef struct packed {
    logic erase_busy;
    logic pcon_idle;
    logic cpu_halted;
    logic pm_active;
    logic halt_by_bkpt;
    logic debug_locked;
    logic osc_stable;
    logic stack_ovf;
  } dbl_status_t;

endpackage : dbl_pkg

// File: design/dbl_cmd_gate.sv
// filters debug commands by the effective debug lock and by the sleep state
// assumes command code and state come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module dbl_cmd_gate
  import dbl_pkg::*;
(
  // command in
  input  wire logic    cmd_valid,
  input  wire dbl_op_t cmd_op,
  // state
  input  wire logic    lock_flag,
  input  wire logic    sleeping,
  // verdict
  output logic         cmd_accept,
  output logic         cmd_reject
);

  logic always_ok;
  logic sleep_ok;
  logic allowed;

  always_comb begin
    always_ok = (cmd_op == OP_CHIP_ERASE) || (cmd_op == OP_READ_STATUS) || (cmd_op == OP_ID_QUERY);
    sleep_ok  = (cmd_op == OP_READ_STATUS) || (cmd_op == OP_ID_QUERY) || (cmd_op == OP_HALT);
    allowed   = (lock_flag || always_ok) && (!sleeping || sleep_ok);  // see [R5] see [R12]
    cmd_accept = cmd_valid && allowed;
    cmd_reject = cmd_valid && !allowed;
  end

endmodule : dbl_cmd_gate
`default_nettype wire

// File: design/dbl_page_guard.sv
// decides whether a flash erase or write may proceed under the page lock bits
// assumes a stable copy of the lock structure on the same clock
`timescale 1ns/1ns
`default_nettype none
module dbl_page_guard
  import dbl_pkg::*;
#(
  parameter int FLASH_PAGES = 128
)(
  // lock structure
  input  wire logic [LOCK_BITS-1:0] lock_struct,
  // request
  input  wire logic [6:0]           page,
  input  wire logic                 in_range,
  input  wire logic                 debug_mode,
  // verdict
  output logic                      permit
);

  logic [LOCK_BITS-1:0] page_open;

  genvar i;
  generate
    for (i = 0; i < LOCK_BITS; i++) begin : g_page
      if (i < FLASH_PAGES - 1) begin : g_used
        assign page_open[i] = lock_struct[i];  // see [R2] see [R3]
      end else begin : g_unused
        assign page_open[i] = 1'b1;  // see [R4]
      end
    end
  endgenerate

  always_comb begin
    if (!in_range) begin
      permit = 1'b0;
    end else if (32'(page) == FLASH_PAGES - 1) begin
      permit = debug_mode;  // see [R9]
    end else begin
      permit = page_open[page];
    end
  end

endmodule : dbl_page_guard
`default_nettype wire

// File: design/dbl_debug_lock.sv
// debug lock, sleep handling, burst byte capture and chip information registers
// assumes command, flash and memory requests come from logic on core_clk
// lock_image is the nonvolatile lock page content, stable around reset
//
// Overview of operation
// [R1] lock structure is 128 bits, 16 bytes at 0x7ff0 when upper bank mapped
// [R2] each page bit guards one page; 0 locked, 1 unlocked
// [R3] bit n maps to page n; bit 127 is the debug lock flag
// [R4] bits for unimplemented pages never affect flash operations
// [R5] flag 0 allows only chip erase, status read and id query
// [R6] status read response carries the debug lock flag
// [R7] a changed flag locks or unlocks only after the next reset
// [R8] only chip erase can return the flag to unlocked
// [R9] rest of the lock page changes only while in debug mode
// [R10] deep sleep in debug keeps regulator on, stops clocks
// [R11] config bit 5 picks emulated sleep or true supply shutdown
// [R12] while asleep until operational, only the sleep subset is accepted
// [R13] halt in sleep wakes to halted; resume restarts execution
// [R14] host polls status after halt wake until power-up completes
// [R15] host avoids debugging in idle or light sleep
// [R16] burst byte register captures each burst write byte
// [R17] each burst byte update raises a dma trigger
// [R18] flash capacity code in chip info low bits 6:4
// [R19] chip info low bit 3 shows usb presence
// [R20] chip info high bits 2:0 hold ram size in kb minus one
// [R21] fixed info bits and read-only version and identifier
// [R22] status bit 2 reads 1 when the debug interface is locked
`timescale 1ns/1ns
`default_nettype none
module dbl_debug_lock
  import dbl_pkg::*;
#(
  parameter int         FLASH_PAGES  = 128,
  parameter logic [2:0] FLASH_CODE   = FLASH_256K,
  parameter logic       HAS_USB      = 1'b0,
  parameter int         RAM_KB       = 8,
  parameter logic [7:0] CHIP_VERSION = 8'h12,   // arbitrary value
  parameter logic [7:0] CHIP_ID      = 8'h5c,   // arbitrary value
  parameter logic [4:0] INFO_HIGH_RSV = 5'h00
)(
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // nonvolatile lock page image
  input  wire logic [127:0]    lock_image,
  // debug command
  input  wire logic            cmd_valid,
  input  wire dbl_cmd_t        cmd,
  output logic                 cmd_accept,
  output logic                 cmd_reject,
  output logic                 resp_valid,
  output logic [7:0]           resp_data,
  output logic                 chip_erase_pulse,
  // debug mode and power
  input  wire logic            debug_entry,
  input  wire logic            sleep_req,
  input  wire logic            wake_event,
  input  wire logic            osc_stable,
  output logic                 debug_mode,
  output logic                 dig_reg_on,
  output logic                 clocks_stop,
  output logic                 cpu_halted,
  // flash request
  input  wire logic            flash_req_valid,
  input  wire dbl_flash_req_t  flash_req,
  output logic                 flash_grant,
  output logic                 flash_deny,
  // memory-space read
  input  wire logic            upper_bank_mapped,
  input  wire logic            mem_rd,
  input  wire logic [15:0]     mem_addr,
  output logic [7:0]           mem_rdata,
  // burst byte dma trigger
  output logic                 debug_byte_dma_trigger
);

  localparam int          FLASH_BYTES = FLASH_PAGES * PAGE_BYTES;
  localparam logic [13:0] STRUCT_LINE = 14'((FLASH_BYTES - LOCK_BYTES) / LOCK_BYTES);
  localparam logic [2:0]  RAM_CODE    = 3'(RAM_KB - 1);
  localparam logic [15:0] WAKE_LAST   = 16'(WAKE_CYC - 1);

  logic [LOCK_BITS-1:0] lock_struct_reg;
  logic                 load_pending_reg;
  logic                 lock_flag_reg;
  logic [7:0]           debug_burst_byte_reg;
  logic                 dma_trigger_reg;
  logic [7:0]           debug_cfg_reg;
  logic                 debug_mode_reg;
  dbl_state_t           state_reg;
  dbl_state_t           state_next;
  logic [15:0]          wake_cnt_reg;
  logic                 wake_to_halt_reg;
  logic                 resp_valid_reg;
  logic [7:0]           resp_data_reg;
  logic                 erase_reg;
  logic [7:0]           mem_rdata_reg;
  logic                 sleeping;
  logic                 permit;
  logic                 in_range;
  logic                 struct_hit;
  dbl_status_t          status;
  logic [7:0]           chip_info_low;
  logic [7:0]           chip_info_high;
  logic [7:0]           rd_byte;

  // command filter
  dbl_cmd_gate u_gate (
    .cmd_valid  (cmd_valid),
    .cmd_op     (cmd.op),
    .lock_flag  (lock_flag_reg),
    .sleeping   (sleeping),
    .cmd_accept (cmd_accept),
    .cmd_reject (cmd_reject)
  );

  // page protection
  dbl_page_guard #(
    .FLASH_PAGES (FLASH_PAGES)
  ) u_guard (
    .lock_struct (lock_struct_reg),
    .page        (flash_req.addr[17:11]),
    .in_range    (in_range),
    .debug_mode  (debug_mode_reg),
    .permit      (permit)
  );

  assign in_range    = 32'(flash_req.addr) < FLASH_BYTES;
  assign struct_hit  = flash_req.addr[17:4] == STRUCT_LINE;
  assign flash_grant = flash_req_valid && permit;
  assign flash_deny  = flash_req_valid && !permit;
  assign sleeping    = (state_reg == ST_SLEEP) || (state_reg == ST_WAKE);

  // lock structure copy: loaded after reset, then tracks writes and erases
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_struct_reg  <= LOCK_ERASED;
      load_pending_reg <= 1'b1;
    end else if (load_pending_reg) begin
      lock_struct_reg  <= lock_image;
      load_pending_reg <= 1'b0;
    end else if (cmd_accept && cmd.op == OP_CHIP_ERASE) begin
      lock_struct_reg <= LOCK_ERASED;  // see [R8]
    end else if (flash_grant && flash_req.erase && struct_hit) begin
      lock_struct_reg[DBG_LOCK_POS-1:0] <= LOCK_ERASED[DBG_LOCK_POS-1:0];  // see [R8]
    end else if (flash_grant && !flash_req.erase && struct_hit) begin
      // flash programming only clears bits, so the flag can never be set here
      lock_struct_reg[{flash_req.addr[3:0], 3'b000} +: 8] <=
        lock_struct_reg[{flash_req.addr[3:0], 3'b000} +: 8] & flash_req.data;  // see [R8] see [R3]
    end
  end

  // effective debug lock, latched once per reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_flag_reg <= 1'b0;
    end else if (load_pending_reg) begin
      lock_flag_reg <= lock_image[DBG_LOCK_POS];  // see [R7]
    end
  end

  // burst write byte and dma trigger
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_burst_byte_reg <= DEBUG_BURST_RST;
      dma_trigger_reg      <= 1'b0;
    end else begin
      dma_trigger_reg <= cmd_accept && cmd.op == OP_BURST_WRITE;  // see [R17]
      if (cmd_accept && cmd.op == OP_BURST_WRITE) begin
        debug_burst_byte_reg <= cmd.data;  // see [R16]
      end
    end
  end

  // debug configuration and debug mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_cfg_reg  <= DEBUG_CFG_RST;
      debug_mode_reg <= 1'b0;
    end else begin
      if (cmd_accept && cmd.op == OP_WR_CONFIG) begin
        debug_cfg_reg <= cmd.data;
      end
      if (state_reg == ST_SLEEP && debug_cfg_reg[CFG_SHUTDOWN_POS]) begin
        debug_mode_reg <= 1'b0;  // see [R11]
      end else if (debug_entry) begin
        debug_mode_reg <= 1'b1;
      end
    end
  end

  // power state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (cmd_accept && cmd.op == OP_HALT) begin
          state_next = ST_HALT;
        end else if (sleep_req) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if ((cmd_accept && cmd.op == OP_HALT) || wake_event) begin
          state_next = ST_WAKE;  // see [R13]
        end
      end
      ST_WAKE: begin
        if (wake_cnt_reg == WAKE_LAST) begin
          state_next = wake_to_halt_reg ? ST_HALT : ST_RUN;  // see [R13]
        end
      end
      ST_HALT: begin
        if (cmd_accept && cmd.op == OP_RESUME) begin
          state_next = ST_RUN;  // see [R13]
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // wake-up timer and wake target
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_reg     <= 16'h0000;
      wake_to_halt_reg <= 1'b0;
    end else if (state_reg == ST_SLEEP) begin
      wake_cnt_reg     <= 16'h0000;
      wake_to_halt_reg <= cmd_accept && cmd.op == OP_HALT;
    end else if (state_reg == ST_WAKE) begin
      wake_cnt_reg <= wake_cnt_reg + 16'h0001;
    end
  end

  // regulator stays on in debug sleep unless shutdown is chosen
  assign dig_reg_on  = !(state_reg == ST_SLEEP && (!debug_mode_reg || debug_cfg_reg[CFG_SHUTDOWN_POS]));  // see [R10] see [R11]
  assign clocks_stop = state_reg == ST_SLEEP;  // see [R10]
  assign debug_mode  = debug_mode_reg;
  assign cpu_halted  = state_reg == ST_HALT;

  // status byte
  always_comb begin
    status              = '0;
    status.erase_busy   = erase_reg;
    status.pcon_idle    = state_reg == ST_SLEEP;
    status.cpu_halted   = state_reg == ST_HALT;
    status.pm_active    = sleeping;  // see [R14]
    status.debug_locked = !lock_flag_reg;  // see [R6] see [R22]
    status.osc_stable   = osc_stable;
  end

  // command responses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= 8'h00;
      erase_reg      <= 1'b0;
    end else begin
      erase_reg      <= cmd_accept && cmd.op == OP_CHIP_ERASE;
      resp_valid_reg <= cmd_accept && (cmd.op == OP_READ_STATUS || cmd.op == OP_ID_QUERY ||
                                       cmd.op == OP_RD_CONFIG);
      unique case (cmd.op)
        OP_READ_STATUS: resp_data_reg <= status;  // see [R6]
        OP_ID_QUERY:    resp_data_reg <= CHIP_ID;
        OP_RD_CONFIG:   resp_data_reg <= debug_cfg_reg;
        default:        resp_data_reg <= resp_data_reg;
      endcase
    end
  end

  assign resp_valid             = resp_valid_reg;
  assign resp_data              = resp_data_reg;
  assign chip_erase_pulse       = erase_reg;
  assign debug_byte_dma_trigger = dma_trigger_reg;

  // chip information
  assign chip_info_low  = {1'b0, FLASH_CODE, HAS_USB, 1'b1, 2'b00};  // see [R18] see [R19] see [R21]
  assign chip_info_high = {INFO_HIGH_RSV, RAM_CODE};  // see [R20]

  always_comb begin
    rd_byte = 8'h00;
    if (upper_bank_mapped && mem_addr[15:4] == OFS_LOCK_STRUCT[15:4]) begin
      rd_byte = lock_struct_reg[{mem_addr[3:0], 3'b000} +: 8];  // see [R1]
    end else begin
      unique case (mem_addr)
        OFS_CHIP_VERSION:    rd_byte = CHIP_VERSION;  // see [R21]
        OFS_CHIP_IDENTIFIER: rd_byte = CHIP_ID;
        OFS_DEBUG_BURST:     rd_byte = debug_burst_byte_reg;
        OFS_CHIP_INFO_LOW:   rd_byte = chip_info_low;
        OFS_CHIP_INFO_HIGH:  rd_byte = chip_info_high;
        default:             rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata_reg <= 8'h00;
    end else if (mem_rd) begin
      mem_rdata_reg <= rd_byte;
    end
  end

  assign mem_rdata = mem_rdata_reg;

  // checks
  localparam int WAKE_MAX = WAKE_CYC + 2;

  property p_dma_follows_burst;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_accept && cmd.op == OP_BURST_WRITE) |=> debug_byte_dma_trigger
        && debug_burst_byte_reg == $past(cmd.data);
  endproperty
  a_dma_follows_burst: assert property (p_dma_follows_burst) else $error("burst byte not captured"); // see [R16]

  property p_trigger_has_cause;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(debug_byte_dma_trigger) || (debug_byte_dma_trigger && !$rose(debug_byte_dma_trigger))
        |-> $past(cmd_accept) && $past(cmd.op) == OP_BURST_WRITE;
  endproperty
  a_trigger_has_cause: assert property (p_trigger_has_cause) else $error("dma trigger without burst"); // see [R17]

  property p_locked_rejects;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_valid && !lock_flag_reg && cmd.op == OP_BURST_WRITE) |-> cmd_reject && !cmd_accept;
  endproperty
  a_locked_rejects: assert property (p_locked_rejects) else $error("locked command accepted"); // see [R5]

  property p_lock_stable;
    @(posedge core_clk) disable iff (!rst_n)
      !$past(load_pending_reg) && !load_pending_reg |-> $stable(lock_flag_reg);
  endproperty
  a_lock_stable: assert property (p_lock_stable) else $error("lock changed without reset"); // see [R7]

  property p_unlock_by_erase;
    @(posedge core_clk) disable iff (!rst_n)
      !$past(load_pending_reg) && $rose(lock_struct_reg[DBG_LOCK_POS])
        |-> $past(cmd_accept) && $past(cmd.op) == OP_CHIP_ERASE;
  endproperty
  a_unlock_by_erase: assert property (p_unlock_by_erase) else $error("flag unlocked without erase"); // see [R8]

  property p_status_lock;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_accept && cmd.op == OP_READ_STATUS) |=> resp_valid && resp_data[2] == !lock_flag_reg;
  endproperty
  a_status_lock: assert property (p_status_lock) else $error("status lock bit wrong"); // see [R22]

  property p_sleep_subset;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_valid && sleeping && cmd.op == OP_RESUME) |-> cmd_reject;
  endproperty
  a_sleep_subset: assert property (p_sleep_subset) else $error("non-sleep command accepted"); // see [R12]

  property p_halt_wake;
    @(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_SLEEP && cmd_accept && cmd.op == OP_HALT) |-> ##[1:WAKE_MAX] state_reg == ST_HALT;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt did not wake to halted"); // see [R13]

  property p_reg_on;
    @(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_SLEEP && debug_mode_reg && !debug_cfg_reg[CFG_SHUTDOWN_POS]) |-> dig_reg_on && clocks_stop;
  endproperty
  a_reg_on: assert property (p_reg_on) else $error("regulator off in emulated sleep"); // see [R10]

  property p_chip_info;
    @(posedge core_clk) disable iff (!rst_n)
      (mem_rd && mem_addr == OFS_CHIP_INFO_LOW) |=> mem_rdata[7] == 1'b0 && mem_rdata[2] == 1'b1
        && mem_rdata[6:4] == FLASH_CODE;
  endproperty
  a_chip_info: assert property (p_chip_info) else $error("chip info low wrong"); // see [R18]

  c_burst: cover property (@(posedge core_clk) disable iff (!rst_n) debug_byte_dma_trigger);
  c_halt_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_WAKE ##1 state_reg == ST_HALT);
  c_locked_reject: cover property (@(posedge core_clk) disable iff (!rst_n) cmd_reject && !lock_flag_reg);
  c_erase: cover property (@(posedge core_clk) disable iff (!rst_n) chip_erase_pulse);

endmodule : dbl_debug_lock
`default_nettype wire

// File: tb/dbl_host_model.sv
// debug host model: sends one command per call and collects the answer
// assumes the block takes commands and answers on core_clk
`timescale 1ns/1ns
`default_nettype none
module dbl_host_model
  import dbl_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // command out
  output logic            cmd_valid,
  output dbl_cmd_t        cmd,
  // answer in
  input  wire logic       cmd_accept,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '{OP_READ_STATUS, 8'h00};
  end
  // idle data is inverted so a stale value never passes
  task automatic send(input dbl_op_t op, input logic [7:0] d, output logic acc, output logic [7:0] rsp);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd       <= '{op, d};
    #1 acc = cmd_accept;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd.data  <= ~d;
    #1 rsp = resp_valid ? resp_data : 8'hxx;
  endtask : send
  // after a halt wake, status is polled until the halted bit shows
  task automatic poll_halted(input int limit, output logic ok);
    logic       a;
    logic [7:0] r;
    ok = 1'b0;
    for (int i = 0; i < limit && !ok; i++) begin
      send(OP_READ_STATUS, 8'h00, a, r);
      ok = (r[5] === 1'b1);
    end
  endtask : poll_halted
endmodule : dbl_host_model
`default_nettype wire

// File: tb/debug_lock_and_chip_info_test.sv
// self-checking bench for the debug lock and chip info block
// assumes the host model drives the command port; bench drives the rest
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module debug_lock_and_chip_info_test;
  import dbl_pkg::*;
  logic                core_clk, rst_n, cmd_valid, cmd_accept, cmd_reject, resp_valid, chip_erase_pulse;
  logic [127:0]        lock_image;
  dbl_cmd_t            cmd;
  logic [7:0]          resp_data, mem_rdata, v, r;
  logic                debug_entry, sleep_req, wake_event, osc_stable, debug_mode, dig_reg_on;
  logic                clocks_stop, cpu_halted, flash_req_valid, flash_grant, flash_deny;
  logic                upper_bank_mapped, mem_rd, trig, a, ok;
  dbl_flash_req_t      flash_req;
  logic [15:0]         mem_addr;
  int                  n_errors, tests_run;
  localparam logic [127:0] IMG_LOCKED = {1'b0, {127{1'b1}}};
  localparam logic [127:0] IMG_OPEN   = {{124{1'b1}}, 4'h7};

  dbl_debug_lock #(.FLASH_CODE(FLASH_64K), .HAS_USB(1'b1), .RAM_KB(4),
    .CHIP_VERSION(8'h21), .CHIP_ID(8'h6e)) dut (   // arbitrary version and id
    .core_clk(core_clk), .rst_n(rst_n), .lock_image(lock_image), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .resp_valid(resp_valid), .resp_data(resp_data),
    .chip_erase_pulse(chip_erase_pulse), .debug_entry(debug_entry), .sleep_req(sleep_req),
    .wake_event(wake_event), .osc_stable(osc_stable), .debug_mode(debug_mode), .dig_reg_on(dig_reg_on),
    .clocks_stop(clocks_stop), .cpu_halted(cpu_halted), .flash_req_valid(flash_req_valid),
    .flash_req(flash_req), .flash_grant(flash_grant), .flash_deny(flash_deny),
    .upper_bank_mapped(upper_bank_mapped), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .debug_byte_dma_trigger(trig));
  dbl_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_accept(cmd_accept),
    .resp_valid(resp_valid), .resp_data(resp_data));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic do_reset(input logic [127:0] img);
    @(posedge core_clk);
    rst_n      <= 1'b0;
    lock_image <= img;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    debug_entry <= 1'b1;
    @(posedge core_clk);
    debug_entry <= 1'b0;
  endtask : do_reset
  task automatic rd(input logic [15:0] ad, output logic [7:0] val);
    @(posedge core_clk);
    mem_rd   <= 1'b1;
    mem_addr <= ad;
    @(posedge core_clk);
    mem_rd <= 1'b0;
    #1 val = mem_rdata;
  endtask : rd
  task automatic fl(input logic [17:0] ad, output logic g);
    @(posedge core_clk);
    flash_req_valid <= 1'b1;
    flash_req       <= '{1'b0, ad, 8'h00};
    #1 g = flash_grant;
    @(posedge core_clk);
    flash_req_valid <= 1'b0;
  endtask : fl
  task automatic test_locked;
    logic [15:0] ad [4];
    logic [7:0]  ex [4];
    ad = '{OFS_CHIP_VERSION, OFS_CHIP_IDENTIFIER, OFS_CHIP_INFO_LOW, OFS_CHIP_INFO_HIGH};
    ex = '{8'h21, 8'h6e, 8'h2c, 8'h03};
    do_reset(IMG_LOCKED);
    host.send(OP_BURST_WRITE, 8'h3c, a, r);
    `CHK("burst accept locked", 1'b0, a)
    `CHK("trigger when locked", 1'b0, trig)
    host.send(OP_ID_QUERY, 8'h00, a, r);
    `CHK("id accept locked", 1'b1, a)
    `CHK("id answer", 8'h6e, r)
    host.send(OP_READ_STATUS, 8'h00, a, r);
    `CHK("status locked bit", 1'b1, r[2])
    for (int i = 0; i < 4; i++) begin
      rd(ad[i], v);
      `CHK("info register", ex[i], v)
    end
    host.send(OP_CHIP_ERASE, 8'h00, a, r);
    `CHK("erase accept locked", 1'b1, a)
    `CHK("erase pulse", 1'b1, chip_erase_pulse)
    host.send(OP_READ_STATUS, 8'h00, a, r);
    `CHK("lock before reset", 1'b1, r[2])
    do_reset({128{1'b1}});
    host.send(OP_READ_STATUS, 8'h00, a, r);
    `CHK("lock after reset", 1'b0, r[2])
  endtask : test_locked
  task automatic test_unlocked;
    do_reset(IMG_OPEN);
    host.send(OP_BURST_WRITE, 8'h3c, a, r);
    `CHK("dma trigger", 1'b1, trig)
    host.send(OP_BURST_WRITE, 8'hc3, a, r);
    rd(OFS_DEBUG_BURST, v);
    `CHK("burst byte", 8'hc3, v)
    fl(18'h01800, a);
    `CHK("locked page grant", 1'b0, a)
    fl(18'h02000, a);
    `CHK("open page grant", 1'b1, a)
    rd(OFS_LOCK_STRUCT, v);
    `CHK("lock byte 0", 8'hf7, v)
    rd(16'h7fff, v);
    `CHK("lock byte 15", 8'hff, v)
    fl(18'h3fff0, a);
    `CHK("top page grant in debug", 1'b1, a)
    rd(OFS_LOCK_STRUCT, v);
    `CHK("lock byte 0 written", 8'h00, v)
    fl(18'h00000, a);
    `CHK("page 0 grant after lock", 1'b0, a)
  endtask : test_unlocked
  task automatic test_sleep;
    // only deep sleep is used while debugging
    @(posedge core_clk);
    sleep_req <= 1'b1;
    @(posedge core_clk);
    sleep_req <= 1'b0;
    #1 `CHK("regulator in sleep", 1'b1, dig_reg_on)
    `CHK("clocks in sleep", 1'b1, clocks_stop)
    host.send(OP_BURST_WRITE, 8'h11, a, r);
    `CHK("burst in sleep", 1'b0, a)
    host.send(OP_HALT, 8'h00, a, r);
    `CHK("halt in sleep", 1'b1, a)
    host.poll_halted(150, ok);
    `CHK("halted after wake", 1'b1, ok)
    if (ok === 1'b1) begin
      `CHK("halted pin", 1'b1, cpu_halted)
      host.send(OP_RESUME, 8'h00, a, r);
      `CHK("running after resume", 1'b0, cpu_halted)
      host.send(OP_WR_CONFIG, 8'h20, a, r);
      @(posedge core_clk);
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      #1 `CHK("regulator shutdown", 1'b0, dig_reg_on)
      @(posedge core_clk);
      #1 `CHK("debug mode shutdown", 1'b0, debug_mode)
    end
  endtask : test_sleep
  task automatic give_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    lock_image = IMG_LOCKED;
    debug_entry = 1'b0;
    sleep_req = 1'b0;
    wake_event = 1'b0;
    osc_stable = 1'b1;
    flash_req_valid = 1'b0;
    flash_req = '0;
    upper_bank_mapped = 1'b1;
    mem_rd = 1'b0;
    mem_addr = 16'h0000;
    test_locked();
    test_unlocked();
    test_sleep();
    give_verdict();
  end
endmodule : debug_lock_and_chip_info_test
`default_nettype wire
